/* cps_consts.vh */
// constants for the capture parser and inline downscaler
`ifndef CPS_CONSTS_VH
`define CPS_CONSTS_VH
`define CPS_BUF_BYTES 4096
`define CPS_PIX_BYTES 2
`define CPS_DIM_W 12
`define CPS_ST_IDLE 2'd0
`define CPS_ST_PULL 2'd1
`define CPS_ST_FAKE 2'd2
`define CPS_ST_WAIT 2'd3
`endif

/* cps_hold_buf.v */
// capture holding buffer that drains toward external memory
`timescale 1ns/1ps
`include "cps_consts.vh"
module cps_hold_buf #(
   parameter DW = 16,
   parameter DEPTH = `CPS_BUF_BYTES / `CPS_PIX_BYTES,
   parameter AW = 11
) (
   // clock and reset
   input wire sys_clk,
   input wire reset_n,
   // fill side
   input wire wr_valid,
   input wire [DW-1:0] wr_data,
   output wire full,
   // drain side
   output wire rd_valid,
   output wire [DW-1:0] rd_data,
   input wire rd_ready
);
   reg [DW-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_reg;
   reg [AW-1:0] rd_ptr_reg;
   reg [AW:0] count_reg;
   wire do_wr;
   wire do_rd;
   assign full = (count_reg == DEPTH[AW:0]);
   assign rd_valid = (count_reg != {(AW+1){1'b0}});
   assign rd_data = mem[rd_ptr_reg];
   assign do_wr = wr_valid && !full;
   assign do_rd = rd_valid && rd_ready;
   always @(posedge sys_clk) begin
      if (do_wr) begin
         mem[wr_ptr_reg] <= wr_data;
      end
   end
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_ptr_reg <= {AW{1'b0}};
         rd_ptr_reg <= {AW{1'b0}};
         count_reg <= {(AW+1){1'b0}};
      end else begin
         if (do_wr) begin
            wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ?
               {AW{1'b0}} : wr_ptr_reg + 1'b1;
         end
         if (do_rd) begin
            rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ?
               {AW{1'b0}} : rd_ptr_reg + 1'b1;
         end
         count_reg <= count_reg + {{AW{1'b0}}, do_wr} -
            {{AW{1'b0}}, do_rd};
      end
   end
endmodule

/* cps_capture.v */
// single-channel capture path with overflow and inline downscaler
`timescale 1ns/1ps
`include "cps_consts.vh"
// Behaviour
// - parser fills 4k-byte buffer, full means overflow
// - overflow drops pixels, frame comes up short
// - scaler holds in/out height and width
// - short frame detected, output padded to size unless resync_enable restarts on the new frame
// - no upstream requests while padding output
// - padding runs every free output cycle, not video timed
// - unpulled video keeps overflowing the parser
// - only inline single-channel; never locks up
// - parser re-enable must not lock later stages
module cps_capture #(
   parameter DW = 16,
   parameter DIM_W = `CPS_DIM_W
) (
   // clock and reset
   input wire sys_clk,
   input wire reset_n,
   // external video pins
   input wire vid_pix_valid,
   input wire vid_frame_start,
   input wire [DW-1:0] vid_pix_data,
   // control
   input wire parser_enable,
   input wire scaler_inline,
   input wire resync_enable,
   input wire [DIM_W-1:0] in_height,
   input wire [DIM_W-1:0] in_width,
   input wire [DIM_W-1:0] out_height,
   input wire [DIM_W-1:0] out_width,
   // drain toward video port dma
   output reg dma_valid_reg,
   output reg [DW-1:0] dma_data_reg,
   input wire dma_ready,
   // status
   output reg overflow_reg,
   output reg drop_pulse_reg,
   output reg mismatch_pulse_reg,
   output reg fabricating_reg,
   output reg pull_req_reg
);
   // two-stage sync of pin inputs
   reg pv_s1_reg, pv_s2_reg, fs_s1_reg, fs_s2_reg;
   reg [DW-1:0] pd_s1_reg, pd_s2_reg;
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         pv_s1_reg <= 1'b0;
         pv_s2_reg <= 1'b0;
         fs_s1_reg <= 1'b0;
         fs_s2_reg <= 1'b0;
         pd_s1_reg <= {DW{1'b0}};
         pd_s2_reg <= {DW{1'b0}};
      end else begin
         pv_s1_reg <= vid_pix_valid;
         pv_s2_reg <= pv_s1_reg;
         fs_s1_reg <= vid_frame_start;
         fs_s2_reg <= fs_s1_reg;
         pd_s1_reg <= vid_pix_data;
         pd_s2_reg <= pd_s1_reg;
      end
   end

   // parser side: buffer between parser and scaler
   wire buf_full, buf_valid;
   wire [DW-1:0] buf_data;
   reg buf_take;
   wire wr_ok;
   wire ovf_hold;
   wire drop_now;
   // overflow state drops until a frame starts with room
   assign ovf_hold = overflow_reg && !(fs_s2_reg && !buf_full);
   // write only while buffer has room
   assign wr_ok = parser_enable && pv_s2_reg && !buf_full && !ovf_hold;
   assign drop_now = parser_enable && pv_s2_reg && (buf_full || ovf_hold);
   cps_hold_buf #(
      .DW(DW)
   ) u_buf (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .wr_valid(wr_ok),
      .wr_data(pd_s2_reg),
      .full(buf_full),
      .rd_valid(buf_valid),
      .rd_data(buf_data),
      .rd_ready(buf_take)
   );

   // disable gates writes and drop detection; scaler state untouched
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         overflow_reg <= 1'b0;
         drop_pulse_reg <= 1'b0;
      end else begin
         drop_pulse_reg <= drop_now;
         // overflow state entered when a pixel meets a full buffer
         // held until a new frame starts with room
         if (drop_now) begin
            overflow_reg <= 1'b1;
         end else if (fs_s2_reg && !buf_full) begin
            overflow_reg <= 1'b0;
         end
      end
   end
   // pixels arriving while full are dropped above

   // scaler
   reg [1:0] state_reg, state_next;
   reg [DIM_W-1:0] ix_reg, iy_reg, ox_reg, oy_reg;
   reg [DIM_W-1:0] ix_next, iy_next, ox_next, oy_next;
   reg frame_seen_reg;
   reg emit, fake, mism;
   wire in_last_x, in_last_y, out_last_x, out_last_y;

   function last_of;
      input [DIM_W-1:0] pos;
      input [DIM_W-1:0] size;
      begin
         last_of = (pos == size - 1'b1) || (size == {DIM_W{1'b0}});
      end
   endfunction

   assign in_last_x = last_of(ix_reg, in_width);
   assign in_last_y = last_of(iy_reg, in_height);
   assign out_last_x = last_of(ox_reg, out_width);
   assign out_last_y = last_of(oy_reg, out_height);

   wire out_room;
   assign out_room = !dma_valid_reg || dma_ready;

   always @* begin
      state_next = state_reg;
      ix_next = ix_reg;
      iy_next = iy_reg;
      ox_next = ox_reg;
      oy_next = oy_reg;
      buf_take = 1'b0;
      emit = 1'b0;
      fake = 1'b0;
      mism = 1'b0;
      case (state_reg)
         `CPS_ST_IDLE: begin
            if (scaler_inline && fs_s2_reg) begin
               state_next = `CPS_ST_PULL;
               ix_next = {DIM_W{1'b0}};
               iy_next = {DIM_W{1'b0}};
               ox_next = {DIM_W{1'b0}};
               oy_next = {DIM_W{1'b0}};
            end
         end
         `CPS_ST_PULL: begin
            // new frame start before output size done means short
            if (fs_s2_reg && frame_seen_reg) begin
               mism = 1'b1;
               state_next = resync_enable ? `CPS_ST_IDLE : `CPS_ST_FAKE;
               // abandon padding and restart on this frame
               if (resync_enable) begin
                  state_next = `CPS_ST_PULL;
                  ix_next = {DIM_W{1'b0}};
                  iy_next = {DIM_W{1'b0}};
                  ox_next = {DIM_W{1'b0}};
                  oy_next = {DIM_W{1'b0}};
               end
            end else if (buf_valid && out_room) begin
               buf_take = 1'b1;
               emit = 1'b1;
               ix_next = in_last_x ? {DIM_W{1'b0}} : ix_reg + 1'b1;
               if (in_last_x) begin
                  iy_next = in_last_y ? {DIM_W{1'b0}} : iy_reg + 1'b1;
               end
            end
         end
         `CPS_ST_FAKE: begin
            // one made-up pixel per free cycle
            if (out_room) begin
               emit = 1'b1;
               fake = 1'b1;
            end
         end
         `CPS_ST_WAIT: begin
            if (fs_s2_reg) begin
               state_next = `CPS_ST_PULL;
            end
         end
         default: begin
            state_next = `CPS_ST_IDLE;
         end
      endcase
      // output walks the programmed output size
      if (emit) begin
         ox_next = out_last_x ? {DIM_W{1'b0}} : ox_reg + 1'b1;
         if (out_last_x) begin
            oy_next = out_last_y ? {DIM_W{1'b0}} : oy_reg + 1'b1;
         end
         // full output size completes the frame
         if (out_last_x && out_last_y) begin
            state_next = `CPS_ST_WAIT;
            ix_next = {DIM_W{1'b0}};
            iy_next = {DIM_W{1'b0}};
         end
      end
      // leaving inline mode always returns to idle
      if (!scaler_inline) begin
         state_next = `CPS_ST_IDLE;
      end
   end

   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= `CPS_ST_IDLE;
         ix_reg <= {DIM_W{1'b0}};
         iy_reg <= {DIM_W{1'b0}};
         ox_reg <= {DIM_W{1'b0}};
         oy_reg <= {DIM_W{1'b0}};
         frame_seen_reg <= 1'b0;
         dma_valid_reg <= 1'b0;
         dma_data_reg <= {DW{1'b0}};
         mismatch_pulse_reg <= 1'b0;
         fabricating_reg <= 1'b0;
         pull_req_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         ix_reg <= ix_next;
         iy_reg <= iy_next;
         ox_reg <= ox_next;
         oy_reg <= oy_next;
         // frame start is a one-cycle pulse; remember one was consumed
         if (state_next != `CPS_ST_PULL) begin
            frame_seen_reg <= 1'b0;
         end else begin
            frame_seen_reg <= 1'b1;
         end
         mismatch_pulse_reg <= mism;
         fabricating_reg <= (state_next == `CPS_ST_FAKE);
         pull_req_reg <= (state_next == `CPS_ST_PULL);
         if (emit) begin
            dma_valid_reg <= 1'b1;
            // padding repeats a blank pixel; cheap, visibly garbled
            dma_data_reg <= fake ? {DW{1'b0}} : buf_data;
         end else if (dma_ready) begin
            dma_valid_reg <= 1'b0;
         end
      end
   end
   // with no pulls the parser keeps overflowing
endmodule

/* cps_capture_properties.sv */
// assertions on the capture path ports
`timescale 1ns/1ps
module cps_capture_props #(
   parameter DW = 16
) (
   // clock and reset
   input wire sys_clk,
   input wire reset_n,
   // control
   input wire scaler_inline,
   input wire resync_enable,
   input wire dma_ready,
   // outputs
   input wire dma_valid_reg,
   input wire [DW-1:0] dma_data_reg,
   input wire overflow_reg,
   input wire drop_pulse_reg,
   input wire mismatch_pulse_reg,
   input wire fabricating_reg,
   input wire pull_req_reg
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   property p_drop; drop_pulse_reg |-> overflow_reg; endproperty
   a_drop: assert property (p_drop) else $error("drop, no overflow");
   property p_ovf; $rose(overflow_reg) |-> drop_pulse_reg; endproperty
   a_ovf: assert property (p_ovf) else $error("overflow, no drop");
   property p_nopull; fabricating_reg |-> !pull_req_reg; endproperty
   a_nopull: assert property (p_nopull) else $error("pull in pad");
   property p_once; mismatch_pulse_reg |=> !mismatch_pulse_reg; endproperty
   a_once: assert property (p_once) else $error("long mismatch");
   property p_pad;
      mismatch_pulse_reg && !resync_enable |-> ##[0:2] fabricating_reg;
   endproperty
   a_pad: assert property (p_pad) else $error("no padding");
   property p_resync;
      mismatch_pulse_reg && resync_enable |-> !fabricating_reg [*3];
   endproperty
   a_resync: assert property (p_resync) else $error("pad on resync");
   property p_rate;
      fabricating_reg && dma_ready ##1 fabricating_reg |-> dma_valid_reg;
   endproperty
   a_rate: assert property (p_rate) else $error("pad gap");
   property p_stand;
      dma_valid_reg && !dma_ready |=> dma_valid_reg && $stable(dma_data_reg);
   endproperty
   a_stand: assert property (p_stand) else $error("output lost");
   property p_idle;
      !scaler_inline ##1 !scaler_inline |-> !pull_req_reg && !fabricating_reg;
   endproperty
   a_idle: assert property (p_idle) else $error("scaler not idle");
   c_drop: cover property (drop_pulse_reg);
   c_pad: cover property ($rose(fabricating_reg));
   c_out: cover property (dma_valid_reg && dma_ready);
endmodule

/* cps_vid_src.sv */
// external video source driving the capture pins
`timescale 1ns/1ps
module cps_vid_src (
   // clock
   input wire logic sys_clk,
   // video pins
   output logic vid_pix_valid = 1'b0,
   output logic vid_frame_start = 1'b0,
   output logic [15:0] vid_pix_data = 16'h0000
);
   // back-to-back pixels, start pulse on the first
   task frame(input int n, input logic [15:0] base);
      for (int i = 0; i < n; i++) begin
         @(posedge sys_clk);
         vid_frame_start <= (i == 0);
         vid_pix_valid <= 1'b1;
         vid_pix_data <= base + 16'(i);
      end
      @(posedge sys_clk);
      vid_frame_start <= 1'b0;
      vid_pix_valid <= 1'b0;
      // idle data inverted so stale pixels never look valid
      vid_pix_data <= ~vid_pix_data;
   endtask
endmodule

/* tb_cps.sv */
// testbench for the capture path and inline scaler
`timescale 1ns/1ps
module tb;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic p_en = 1'b1;
   logic inl = 1'b1;
   logic rs = 1'b0;
   logic rdy = 1'b1;
   logic [11:0] h = 12'h002;
   logic [11:0] w = 12'h004;
   logic [3:0] seen;
   logic [15:0] q[$];
   wire pv, fs, vld, ovf, drp, mis, fab, pull;
   wire [15:0] pd, dat;
   int bad_count = 0;
   int comparisons = 0;
   always #12.5 sys_clk = ~sys_clk;
   cps_vid_src i_src (.sys_clk(sys_clk), .vid_pix_valid(pv),
      .vid_frame_start(fs), .vid_pix_data(pd));
   cps_capture i_dut (.sys_clk(sys_clk), .reset_n(reset_n),
      .vid_pix_valid(pv), .vid_frame_start(fs), .vid_pix_data(pd),
      .parser_enable(p_en), .scaler_inline(inl), .resync_enable(rs),
      .in_height(h), .in_width(w), .out_height(h), .out_width(w),
      .dma_valid_reg(vld), .dma_data_reg(dat), .dma_ready(rdy),
      .overflow_reg(ovf), .drop_pulse_reg(drp),
      .mismatch_pulse_reg(mis), .fabricating_reg(fab),
      .pull_req_reg(pull));
   always @(posedge sys_clk) begin
      if (vld === 1'b1 && rdy === 1'b1)
         q.push_back(dat);
      seen <= !reset_n ? 4'h0 : seen | {ovf, drp, mis, fab};
   end
   task chk(input string nm, input logic [15:0] got, exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s exp %h got %h", nm, exp, got);
      end
   endtask
   task rst(input logic r, input logic [11:0] hh, ww);
      @(posedge sys_clk);
      reset_n <= 1'b0;
      rs <= r;
      h <= hh;
      w <= ww;
      repeat (4) @(posedge sys_clk);
      q.delete();
      reset_n <= 1'b1;
      @(posedge sys_clk);
   endtask
   task end_of_test;
      $display("checks %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // whole run is near 6600 cycles
   initial begin
      repeat (20000) @(posedge sys_clk);
      bad_count++;
      end_of_test();
   end
   initial begin
      rst(1'b0, 12'h002, 12'h004);
      i_src.frame(8, 16'h0010);
      repeat (20) @(posedge sys_clk);
      chk("count", 16'(q.size()), 16'h0008);
      for (int i = 0; i < 8; i++) chk("pix", q[i], 16'h0010 + 16'(i));
      $display("test pass-through done");
      // same short frame, padded then resynced
      for (int r = 0; r < 2; r++) begin
         rst(r[0], 12'h002, 12'h004);
         i_src.frame(3, 16'h0020);
         i_src.frame(8, 16'h0030);
         repeat (40) @(posedge sys_clk);
         chk("mismatch", 16'(seen[1]), 16'h0001);
         chk("padding", 16'(seen[0]), r ? 16'h0000 : 16'h0001);
         chk("count", 16'(q.size()), r ? 16'h000b : 16'h0008);
         chk("tail", q[q.size()-1], r ? 16'h0037 : 16'h0000);
         $display("test short frame done");
      end
      // long padding run leaves the next frame unpulled
      rst(1'b0, 12'h040, 12'h040);
      i_src.frame(3, 16'h0100);
      i_src.frame(2100, 16'h0200);
      chk("re-overflow", 16'(seen[3]), 16'h0001);
      chk("pad run", 16'(seen[0]), 16'h0001);
      $display("test repeated overflow done");
      // stalled drain: buffer fills, later pixels drop
      rst(1'b0, 12'h040, 12'h040);
      rdy <= 1'b0;
      i_src.frame(2100, 16'h0000);
      chk("overflow", 16'(seen[3]), 16'h0001);
      chk("drop", 16'(seen[2]), 16'h0001);
      rdy <= 1'b1;
      repeat (2200) @(posedge sys_clk);
      chk("first", q[0], 16'h0000);
      chk("kept", q[2047], 16'h07ff);
      $display("test overflow done");
      // parser and scaler toggled before a frame
      rst(1'b0, 12'h002, 12'h004);
      p_en <= 1'b0;
      inl <= 1'b0;
      repeat (3) @(posedge sys_clk);
      p_en <= 1'b1;
      inl <= 1'b1;
      i_src.frame(8, 16'h0040);
      repeat (20) @(posedge sys_clk);
      chk("restart", q[7], 16'h0047);
      $display("test re-enable done");
      end_of_test();
   end
endmodule
bind cps_capture cps_capture_props #(.DW(DW)) i_props (.sys_clk(sys_clk),
   .reset_n(reset_n), .scaler_inline(scaler_inline),
   .resync_enable(resync_enable), .dma_ready(dma_ready),
   .dma_valid_reg(dma_valid_reg), .dma_data_reg(dma_data_reg),
   .overflow_reg(overflow_reg), .drop_pulse_reg(drop_pulse_reg),
   .mismatch_pulse_reg(mismatch_pulse_reg),
   .fabricating_reg(fabricating_reg), .pull_req_reg(pull_req_reg));
